// ### bench/umpr_line_model.sv
// Remote serial device: sends frames to the channel, decodes its output
`timescale 1ns/1ps
module umpr_line_model (
  input wire logic mclk, // System clock
  input wire logic tx_line, // Channel output line
  output logic rx_line // Channel input line
);
  int bit_cyc = 16; // Bit time in clocks
  int n_got = 0; // Bytes decoded
  logic [7:0] got = 8'h00; // Last byte decoded
  logic [7:0] sh;

  initial rx_line = 1'b1;

  task automatic hold;
    repeat (bit_cyc) @(posedge mclk);
  endtask : hold

  // Stop level and gap are arguments so that faults can be commanded
  task automatic send_frame(input logic [7:0] d, input int nb,
    input logic par_on, input logic pbit, input logic stop, input int gap);
    @(posedge mclk);
    rx_line <= 1'b0;
    hold();
    for (int i = 0; i < nb; i++) begin
      rx_line <= d[i];
      hold();
    end
    if (par_on) begin
      rx_line <= pbit;
      hold();
    end
    rx_line <= stop;
    hold();
    rx_line <= 1'b1;
    repeat (gap) @(posedge mclk);
  endtask : send_frame

  // Mid-bit sampling, LSB first, eight bits
  always begin
    @(negedge tx_line);
    repeat (bit_cyc / 2) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      hold();
      sh[i] = tx_line;
    end
    hold();
    got = sh;
    n_got++;
  end
endmodule : umpr_line_model

// ### bench/umpr_uart_tb.sv
// Self-checking bench for the asynchronous serial channel
`timescale 1ns/1ps
module umpr_uart_tb
  import umpr_pkg::*;
;
  logic mclk, tx_busy, rx_full, line_rx, line_tx;
  logic srst = 1'b1, bdc_wr = 1'b0, tx_wr = 1'b0, rx_rd = 1'b0;
  logic listen = 1'b0, ext_clk = 1'b0;
  logic [2:0] ext_div = 3'h0;
  logic [1:0] sel = 2'h0;
  logic [7:0] bdc_wdata = 8'h00, tx_wdata = 8'h00, bdc_rb, rx_buffer, d;
  umpr_amc_t amc = '0;
  umpr_smc_t smc = '0;
  umpr_status_t status;
  umpr_pin_t port_out = '0, port_oe = '0, pin_in, pin_out, pin_oe;
  int mismatches = 0, n_checks = 0, cyc_cnt = 0;
  logic [7:0] q[$];

  umpr_uart #(.FIFO_DEPTH(16)) DUT (
    .mclk(mclk), .srst(srst), .async_mode_control(amc),
    .sync_mode_control(smc), .line_pin_select(sel), .bdc_wr(bdc_wr),
    .bdc_wdata(bdc_wdata), .baud_divider_control(bdc_rb), .tx_wr(tx_wr),
    .tx_wdata(tx_wdata), .tx_busy(tx_busy), .rx_rd(rx_rd),
    .rx_buffer(rx_buffer), .rx_full(rx_full), .rx_error_status(status),
    .port_out(port_out), .port_oe(port_oe), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe)
  );
  umpr_line_model line_dev (
    .mclk(mclk), .tx_line(line_tx), .rx_line(line_rx)
  );

  // Model listens only in its own transfers; port traffic is noise
  assign line_tx = !listen ? 1'b1 : sel[1] ? pin_out.alternate_tx_pin :
    pin_out.primary_tx_pin;
  // Unselected receive pin idles high, so a wrong route loses the frame
  assign pin_in = {ext_clk, sel[0] ? line_rx : 1'b1, pin_out.alternate_tx_pin,
    pin_out.primary_tx_pin, sel[0] ? 1'b1 : line_rx};

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // External baud clock: one rising edge per 8 system clocks
  always @(posedge mclk) begin
    ext_div <= ext_div + 3'h1;
    ext_clk <= ext_div[2];
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 60000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic check(input string nm, input logic [7:0] s,
    input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  task automatic complete_run();
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  function automatic umpr_amc_t mk(input logic t, r, input umpr_par_t p,
    input logic l, sl, ci);
    return '{t, r, p, l, sl, 1'b0, ci};
  endfunction : mk

  function automatic logic par_bit(input logic [1:0] pm,
    input logic [7:0] v, input int nb);
    logic x;
    x = (nb == 7) ? ^v[6:0] : ^v;
    return (pm == 2'h2) ? ~x : (pm == 2'h3) ? x : 1'b0;
  endfunction : par_bit

  task automatic set_div(input logic [7:0] v);
    @(posedge mclk);
    bdc_wr <= 1'b1;
    bdc_wdata <= v;
    @(posedge mclk);
    bdc_wr <= 1'b0;
    @(negedge mclk);
    check("divider", bdc_rb, v);
    line_dev.bit_cyc = 16 * (int'(v) + 1);
  endtask : set_div

  task automatic set_mode(input umpr_amc_t a, input logic [1:0] s);
    logic [4:0] m;
    m = (a.tx_enable_bit ? (s[1] ? 5'h06 : 5'h02) : 5'h00) |
      (a.rx_enable_bit ? (s[0] ? 5'h08 : 5'h01) : 5'h00) |
      (a.clk_internal ? 5'h00 : 5'h10);
    @(posedge mclk);
    amc <= a;
    sel <= s;
    port_out <= 5'($urandom);
    port_oe <= 5'($urandom);
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    check("port out", {3'h0, pin_out & ~m}, {3'h0, port_out & ~m});
    check("port oe", {3'h0, pin_oe & ~m}, {3'h0, port_oe & ~m});
    check("line oe", {3'h0, pin_oe & m & 5'h06}, {3'h0, m & 5'h06});
    check("line hi", {3'h0, pin_out & m & 5'h06}, {3'h0, m & 5'h06});
    check("in oe", {3'h0, pin_oe & m & 5'h19}, 8'h00);
  endtask : set_mode

  task automatic tx_byte(input logic [7:0] v, input logic [7:0] e);
    int n0;
    n0 = line_dev.n_got;
    @(posedge mclk);
    listen <= 1'b1;
    tx_wr <= 1'b1;
    tx_wdata <= v;
    @(posedge mclk);
    tx_wr <= 1'b0;
    @(negedge mclk);
    check("busy", {7'h0, tx_busy}, 8'h01);
    check("start", {7'h0, line_tx}, 8'h00);
    if (sel[1]) check("pri tx", {7'h0, pin_out.primary_tx_pin}, 8'h01);
    for (int i = 0; i < 3000 && line_dev.n_got == n0; i++) @(posedge mclk);
    check("tx byte", line_dev.got, e);
    for (int i = 0; i < 3000 && tx_busy !== 1'b0; i++) @(posedge mclk);
    listen <= 1'b0;
  endtask : tx_byte

  task automatic rx_check(input logic [7:0] e, input logic [7:0] st);
    check("status", status, st);
    check("full", {7'h0, rx_full}, 8'h01);
    check("rx data", rx_buffer, e);
    @(posedge mclk);
    rx_rd <= 1'b1;
    @(posedge mclk);
    rx_rd <= 1'b0;
    @(negedge mclk);
  endtask : rx_check

  task automatic rx_frame(input logic [7:0] v, input int nb,
    input logic [1:0] pm, input logic bad, stop, input logic [7:0] st);
    line_dev.send_frame(v, nb, pm != 2'h0, par_bit(pm, v, nb) ^ bad, stop,
      16);
    @(negedge mclk);
    rx_check(nb == 7 ? {1'b0, v[6:0]} : v, st);
  endtask : rx_frame

  initial begin
    umpr_amc_t a;
    void'($urandom(67));
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    @(negedge mclk);
    check("status", status, 8'h00);
    check("divider", bdc_rb, 8'h00);
    check("buffer", rx_buffer, 8'hff);
    set_div(8'($urandom));
    set_div(8'h00);
    // Every route, then the external baud clock
    for (int s = 0; s < 5; s++) begin
      a = mk(s != 1, s != 2, UMPR_PAR_NONE, 1'b1, 1'b0, s != 4);
      set_mode(a, (s == 4) ? 2'h0 : 2'(s));
      line_dev.bit_cyc = (s == 4) ? 128 : 16;
      d = 8'($urandom);
      if (a.tx_enable_bit) tx_byte(d, d);
      if (a.rx_enable_bit) rx_frame(d, 8, 2'h0, 1'b0, 1'b1, 8'h00);
    end
    // Any sync control bit is prohibited: the ports must own every pin
    @(posedge mclk);
    smc <= 8'h80;
    port_oe <= '0;
    @(negedge mclk);
    check("sync oe", {3'h0, pin_oe}, 8'h00);
    @(posedge mclk);
    smc <= 8'h00;
    line_dev.bit_cyc = 16;
    set_mode(mk(1'b1, 1'b1, UMPR_PAR_NONE, 1'b0, 1'b0, 1'b1), 2'h0);
    d = 8'($urandom);
    tx_byte(d, {1'b1, d[6:0]});
    rx_frame(d, 7, 2'h0, 1'b0, 1'b1, 8'h00);
    // Even, odd and zero parity, each clean and then corrupted
    for (int i = 0; i < 6; i++) begin
      set_mode(mk(1'b0, 1'b1, umpr_par_t'(3 - i / 2), 1'b1, 1'b0, 1'b1),
        2'h0);
      rx_frame(8'($urandom), 8, 2'(3 - i / 2), i[0], 1'b1,
        {5'h0, i[0], 2'h0});
    end
    set_mode(mk(1'b1, 1'b1, UMPR_PAR_NONE, 1'b1, 1'b1, 1'b1), 2'h0);
    rx_frame(8'($urandom), 8, 2'h0, 1'b0, 1'b0, 8'h02);
    d = 8'($urandom);
    tx_byte(d, d);
    q = '{8'($urandom), 8'($urandom)};
    line_dev.send_frame(q[0], 8, 1'b0, 1'b0, 1'b1, 0);
    line_dev.send_frame(q[1], 8, 1'b0, 1'b0, 1'b1, 16);
    @(negedge mclk);
    rx_check(q[0], 8'h00);
    rx_check(q[1], 8'h00);
    // Buffer plus 16-word queue, then two overruns
    q.delete();
    for (int i = 0; i < 19; i++) begin
      d = 8'($urandom);
      if (i < 17) q.push_back(d);
      line_dev.send_frame(d, 8, 1'b0, 1'b0, 1'b1, 4);
      @(negedge mclk);
      if (i > 16) check("overrun", status, 8'h01);
    end
    while (q.size() > 0) rx_check(q.pop_front(), 8'h01);
    check("empty", {7'h0, rx_full}, 8'h00);
    rx_frame(8'($urandom), 8, 2'h0, 1'b0, 1'b1, 8'h00);
    complete_run();
  end
endmodule : umpr_uart_tb

// ### pkg/umpr_pkg.sv
// Shared types and constants for the asynchronous serial channel
package umpr_pkg;

  // ----------------------------------------
  // Reset values and counts
  // ----------------------------------------
  localparam logic [7:0] UMPR_STATUS_RST = 8'h00;
  localparam logic [7:0] UMPR_BDC_RST = 8'h00;
  localparam logic [7:0] UMPR_RXBUF_RST = 8'hff;
  localparam logic [3:0] UMPR_SAMPLE_PT = 4'h7;
  localparam logic [3:0] UMPR_OVS_LAST = 4'hf;
  localparam logic [2:0] UMPR_LAST_BIT8 = 3'h7;
  localparam logic [2:0] UMPR_LAST_BIT7 = 3'h6;

  // ----------------------------------------
  // Pin routing codes
  // ----------------------------------------
  localparam logic [1:0] UMPR_SEL_PRI = 2'h0;
  localparam logic [1:0] UMPR_SEL_RXALT = 2'h1;
  localparam logic [1:0] UMPR_SEL_TXALT = 2'h2;
  localparam logic [1:0] UMPR_SEL_BOTH = 2'h3;

  // ----------------------------------------
  // Register layouts
  // ----------------------------------------
  typedef enum logic [1:0] {
    UMPR_PAR_NONE, UMPR_PAR_ZERO, UMPR_PAR_ODD, UMPR_PAR_EVEN
  } umpr_par_t;

  typedef struct packed {
    logic tx_enable_bit;
    logic rx_enable_bit;
    umpr_par_t parity_mode;
    logic char_len8;
    logic stop_length_select;
    logic rsvd;
    logic clk_internal;
  } umpr_amc_t;

  typedef struct packed {
    logic sync_enable_bit;
    logic [3:0] rsvd_hi;
    logic sync_bit_order;
    logic sync_clock_select;
    logic rsvd_lo;
  } umpr_smc_t;

  typedef struct packed {
    logic [4:0] rsvd;
    logic parity_err;
    logic framing_err;
    logic overrun_err;
  } umpr_status_t;

  typedef struct packed {
    logic ext_baud_clock_pin;
    logic alternate_rx_pin;
    logic alternate_tx_pin;
    logic primary_tx_pin;
    logic primary_rx_pin;
  } umpr_pin_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP
  } umpr_st_t;

endpackage : umpr_pkg

// ### src/umpr_fifo.sv
// Receive data queue with valid/ready on both sides
`timescale 1ns/1ps
module umpr_fifo #(
  parameter int WIDTH = 8, // Word width
  parameter int DEPTH = 16 // Number of words
) (
  input wire logic mclk, // System clock
  input wire logic srst, // Synchronous reset, high
  input wire logic in_valid, // Word offered
  output logic in_ready, // Room for a word
  input wire logic [WIDTH-1:0] in_data, // Word in
  output logic out_valid, // Word available
  input wire logic out_ready, // Consumer takes word
  output logic [WIDTH-1:0] out_data // Oldest word
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [AW:0] cnt_ff, nxt_cnt;
  logic push, pop;

  assign in_ready = cnt_ff != DEPTH[AW:0];
  assign out_valid = cnt_ff != '0;
  assign out_data = mem[rp_ff];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    nxt_wp = push ? AW'(wp_ff + 1'b1) : wp_ff;
    nxt_rp = pop ? AW'(rp_ff + 1'b1) : rp_ff;
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = (AW+1)'(cnt_ff + 1'b1);
    end else if (pop && !push) begin
      nxt_cnt = (AW+1)'(cnt_ff - 1'b1);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

  // Storage needs no reset; emptiness is tracked by the count
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wp_ff] <= in_data;
    end
  end
endmodule : umpr_fifo

// ### src/umpr_uart.sv
// Asynchronous serial channel: pins, baud clock, framing, error status
`timescale 1ns/1ps
module umpr_uart
  import umpr_pkg::*;
#(
  parameter int FIFO_DEPTH = 16 // Receive queue depth
) (
  input wire logic mclk, // System clock, 50 MHz
  input wire logic srst, // Synchronous reset, high
  input wire umpr_amc_t async_mode_control, // Async mode bits
  input wire umpr_smc_t sync_mode_control, // Sync mode bits
  input wire logic [1:0] line_pin_select, // Pin routing
  input wire logic bdc_wr, // Byte write of divider
  input wire logic [7:0] bdc_wdata, // Divider write data
  output logic [7:0] baud_divider_control, // Divider readback
  input wire logic tx_wr, // Write to shared data address
  input wire logic [7:0] tx_wdata, // Transmit data
  output logic tx_busy, // Frame being sent
  input wire logic rx_rd, // Read of shared data address
  output logic [7:0] rx_buffer, // Receive buffer
  output logic rx_full, // Buffer holds unread data
  output umpr_status_t rx_error_status, // Error status
  input wire umpr_pin_t port_out, // Port latch values
  input wire umpr_pin_t port_oe, // Port drive enables
  input wire umpr_pin_t pin_in, // Pin levels
  output umpr_pin_t pin_out, // Pin output values
  output umpr_pin_t pin_oe // Pin drive enables
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [2:0] s1_ff, s2_ff, s3_ff, filt_ff, nxt_filt;
  logic clk_prev_ff;
  logic rx_line;

  always_comb begin
    nxt_filt = (s2_ff == s3_ff) ? s3_ff : filt_ff;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s1_ff <= 3'h7;
      s2_ff <= 3'h7;
      s3_ff <= 3'h7;
      filt_ff <= 3'h7;
      clk_prev_ff <= 1'b1;
    end else begin
      s1_ff <= {pin_in.ext_baud_clock_pin, pin_in.alternate_rx_pin,
                pin_in.primary_rx_pin};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      filt_ff <= nxt_filt;
      clk_prev_ff <= filt_ff[2];
    end
  end

  assign rx_line = line_pin_select[0] ? filt_ff[1] : filt_ff[0];

  // ----------------------------------------
  // Mode legality
  // ----------------------------------------
  logic legal, tx_on, rx_on, pin_ok;

  always_comb begin
    case (line_pin_select)
      UMPR_SEL_PRI: pin_ok = 1'b1;
      UMPR_SEL_RXALT: pin_ok = !async_mode_control.tx_enable_bit;
      UMPR_SEL_TXALT: pin_ok = !async_mode_control.rx_enable_bit;
      default: pin_ok = 1'b1;
    endcase
  end

  assign legal = pin_ok && (sync_mode_control == '0);
  assign tx_on = legal && async_mode_control.tx_enable_bit;
  assign rx_on = legal && async_mode_control.rx_enable_bit;

  // ----------------------------------------
  // Baud tick
  // ----------------------------------------
  logic [7:0] bdc_ff, nxt_bdc, pre_ff, nxt_pre;
  logic tick;

  // divider only has a whole-byte write port
  always_comb begin
    nxt_bdc = bdc_wr ? bdc_wdata : bdc_ff;
    nxt_pre = (bdc_wr || pre_ff == bdc_ff) ? '0 : 8'(pre_ff + 8'h01);
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      bdc_ff <= UMPR_BDC_RST;
      pre_ff <= '0;
    end else begin
      bdc_ff <= nxt_bdc;
      pre_ff <= nxt_pre;
    end
  end

  assign tick = async_mode_control.clk_internal ? (pre_ff == bdc_ff) :
                (filt_ff[2] & ~clk_prev_ff);
  assign baud_divider_control = bdc_ff;

  property p_bdc_reset;
    @(posedge mclk) disable iff (1'b0)
      srst |=> baud_divider_control == UMPR_BDC_RST;
  endproperty
  a_bdc_reset: assert property (p_bdc_reset)
    else $error("divider not cleared by reset");

  function automatic logic par_of(logic [7:0] d, logic c8, umpr_par_t m);
    logic [7:0] x;
    x = c8 ? d : {1'b0, d[6:0]};
    case (m)
      UMPR_PAR_ODD: par_of = ~^x;
      UMPR_PAR_EVEN: par_of = ^x;
      default: par_of = 1'b0;
    endcase
  endfunction : par_of

  logic [2:0] last_bit;
  assign last_bit = async_mode_control.char_len8 ? UMPR_LAST_BIT8 :
                    UMPR_LAST_BIT7;

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  umpr_st_t tx_st_ff, nxt_tx_st;
  logic [3:0] tx_cnt_ff, nxt_tx_cnt;
  logic [2:0] tx_bit_ff, nxt_tx_bit;
  logic [7:0] tx_sh_ff, nxt_tx_sh;
  logic tx_par_ff, nxt_tx_par, tx_line_ff, nxt_tx_line;

  always_comb begin
    nxt_tx_st = tx_st_ff;
    nxt_tx_cnt = tx_cnt_ff;
    nxt_tx_bit = tx_bit_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_tx_par = tx_par_ff;
    nxt_tx_line = tx_line_ff;
    if (tx_st_ff == ST_IDLE) begin
      nxt_tx_line = 1'b1;
      // a write loads the transmit shifter
      if (tx_wr && tx_on) begin
        nxt_tx_sh = tx_wdata;
        nxt_tx_par = par_of(tx_wdata, async_mode_control.char_len8,
                            async_mode_control.parity_mode);
        nxt_tx_cnt = '0;
        nxt_tx_line = 1'b0;
        nxt_tx_st = ST_START;
      end
    end else if (tick) begin
      nxt_tx_cnt = 4'(tx_cnt_ff + 4'h1);
      if (tx_cnt_ff == UMPR_OVS_LAST) begin
        case (tx_st_ff)
          ST_START: begin
            nxt_tx_line = tx_sh_ff[0];
            nxt_tx_bit = '0;
            nxt_tx_st = ST_DATA;
          end
          ST_DATA: begin
            nxt_tx_sh = {1'b0, tx_sh_ff[7:1]};
            nxt_tx_line = tx_sh_ff[1];
            nxt_tx_bit = 3'(tx_bit_ff + 3'h1);
            if (tx_bit_ff == last_bit) begin
              nxt_tx_bit = '0;
              if (async_mode_control.parity_mode == UMPR_PAR_NONE) begin
                nxt_tx_line = 1'b1;
                nxt_tx_st = ST_STOP;
              end else begin
                nxt_tx_line = tx_par_ff;
                nxt_tx_st = ST_PAR;
              end
            end
          end
          ST_PAR: begin
            nxt_tx_line = 1'b1;
            nxt_tx_st = ST_STOP;
          end
          default: begin
            if (async_mode_control.stop_length_select && tx_bit_ff == '0) begin
              nxt_tx_bit = 3'h1;
            end else begin
              nxt_tx_st = ST_IDLE;
            end
          end
        endcase
      end
    end
    if (!tx_on) begin
      nxt_tx_st = ST_IDLE;
      nxt_tx_line = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_st_ff <= ST_IDLE;
      tx_cnt_ff <= '0;
      tx_bit_ff <= '0;
      tx_sh_ff <= '0;
      tx_par_ff <= 1'b0;
      tx_line_ff <= 1'b1;
    end else begin
      tx_st_ff <= nxt_tx_st;
      tx_cnt_ff <= nxt_tx_cnt;
      tx_bit_ff <= nxt_tx_bit;
      tx_sh_ff <= nxt_tx_sh;
      tx_par_ff <= nxt_tx_par;
      tx_line_ff <= nxt_tx_line;
    end
  end

  assign tx_busy = tx_st_ff != ST_IDLE;

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  umpr_st_t rx_st_ff, nxt_rx_st;
  logic [3:0] rx_cnt_ff, nxt_rx_cnt;
  logic [2:0] rx_bit_ff, nxt_rx_bit;
  logic [7:0] rx_sh_ff, nxt_rx_sh, rx_word;
  logic rx_pe_ff, nxt_rx_pe, rx_done, rx_fe;

  // seven-bit frames sit low with a zero top bit
  assign rx_word = async_mode_control.char_len8 ? rx_sh_ff :
                   {1'b0, rx_sh_ff[7:1]};

  always_comb begin
    nxt_rx_st = rx_st_ff;
    nxt_rx_cnt = rx_cnt_ff;
    nxt_rx_bit = rx_bit_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_rx_pe = rx_pe_ff;
    rx_done = 1'b0;
    rx_fe = 1'b0;
    if (rx_st_ff == ST_IDLE) begin
      if (!rx_line) begin
        nxt_rx_cnt = '0;
        nxt_rx_st = ST_START;
      end
    end else if (tick) begin
      nxt_rx_cnt = 4'(rx_cnt_ff + 4'h1);
      case (rx_st_ff)
        ST_START: begin
          // Mid-bit recheck rejects glitches
          if (rx_cnt_ff == UMPR_SAMPLE_PT) begin
            nxt_rx_cnt = '0;
            nxt_rx_bit = '0;
            nxt_rx_pe = 1'b0;
            nxt_rx_st = rx_line ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (rx_cnt_ff == UMPR_OVS_LAST) begin
            nxt_rx_sh = {rx_line, rx_sh_ff[7:1]};
            nxt_rx_bit = 3'(rx_bit_ff + 3'h1);
            if (rx_bit_ff == last_bit) begin
              nxt_rx_st = (async_mode_control.parity_mode == UMPR_PAR_NONE)
                          ? ST_STOP : ST_PAR;
            end
          end
        end
        ST_PAR: begin
          if (rx_cnt_ff == UMPR_OVS_LAST) begin
            nxt_rx_pe = rx_line ^ par_of(rx_word, 1'b1,
                                         async_mode_control.parity_mode);
            nxt_rx_st = ST_STOP;
          end
        end
        default: begin
          // a single stop bit ends every frame
          if (rx_cnt_ff == UMPR_OVS_LAST) begin
            rx_done = 1'b1;
            rx_fe = !rx_line;
            nxt_rx_st = ST_IDLE;
          end
        end
      endcase
    end
    if (!rx_on) begin
      nxt_rx_st = ST_IDLE;
      rx_done = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rx_st_ff <= ST_IDLE;
      rx_cnt_ff <= '0;
      rx_bit_ff <= '0;
      rx_sh_ff <= '0;
      rx_pe_ff <= 1'b0;
    end else begin
      rx_st_ff <= nxt_rx_st;
      rx_cnt_ff <= nxt_rx_cnt;
      rx_bit_ff <= nxt_rx_bit;
      rx_sh_ff <= nxt_rx_sh;
      rx_pe_ff <= nxt_rx_pe;
    end
  end

  // ----------------------------------------
  // Queue, buffer and error status
  // ----------------------------------------
  logic fq_in_ready, fq_out_valid, fq_out_ready, ovr_now, load;
  logic [7:0] fq_out_data, rxb_ff, nxt_rxb;
  logic rxb_full_ff, nxt_rxb_full, ovr_pend_ff, nxt_ovr_pend;
  umpr_status_t st_ff, nxt_st;

  umpr_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .srst(srst),
    .in_valid(rx_done),
    .in_ready(fq_in_ready),
    .in_data(rx_word),
    .out_valid(fq_out_valid),
    .out_ready(fq_out_ready),
    .out_data(fq_out_data)
  );

  assign load = fq_out_valid && (!rxb_full_ff || rx_rd);
  assign fq_out_ready = load;
  // overrun repeats until the buffer is read
  assign ovr_now = !fq_in_ready || (ovr_pend_ff && !rx_rd);

  always_comb begin
    nxt_rxb = load ? fq_out_data : rxb_ff;
    nxt_rxb_full = load || (rxb_full_ff && !rx_rd);
    // Set wins over the read that clears it
    nxt_ovr_pend = (rx_done && ovr_now) || (ovr_pend_ff && !rx_rd);
    nxt_st = st_ff;
    // record error kinds; held while sync mode owns the channel
    if (rx_done && !sync_mode_control.sync_enable_bit) begin
      nxt_st = '{rsvd: '0, parity_err: rx_pe_ff, framing_err: rx_fe,
                 overrun_err: ovr_now};
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rxb_ff <= UMPR_RXBUF_RST;
      rxb_full_ff <= 1'b0;
      ovr_pend_ff <= 1'b0;
      st_ff <= UMPR_STATUS_RST;
    end else begin
      rxb_ff <= nxt_rxb;
      rxb_full_ff <= nxt_rxb_full;
      ovr_pend_ff <= nxt_ovr_pend;
      st_ff <= nxt_st;
    end
  end

  // whole byte out, every bit individually visible
  assign rx_error_status = st_ff;
  assign rx_buffer = rxb_ff;
  assign rx_full = rxb_full_ff;

  sequence s_frame_end;
    rx_done && !sync_mode_control.sync_enable_bit;
  endsequence
  sequence s_stop_ok;
    rx_st_ff == ST_STOP && tick && rx_cnt_ff == UMPR_OVS_LAST && rx_line
      && rx_on;
  endsequence

  property p_status_reset;
    @(posedge mclk) disable iff (1'b0)
      srst |=> rx_error_status == UMPR_STATUS_RST;
  endproperty
  a_status_reset: assert property (p_status_reset)
    else $error("status not cleared by reset");
  property p_err_record;
    s_frame_end |=> rx_error_status.parity_err == $past(rx_pe_ff)
      && rx_error_status.framing_err == $past(rx_fe);
  endproperty
  a_err_record: assert property (p_err_record)
    else $error("error kind not recorded");
  property p_ovr_sticky;
    s_frame_end ##0 (ovr_pend_ff && !rx_rd) |=> rx_error_status.overrun_err
      && ovr_pend_ff;
  endproperty
  a_ovr_sticky: assert property (p_ovr_sticky)
    else $error("overrun not repeated before buffer read");
  property p_one_stop;
    s_stop_ok |=> rx_st_ff == ST_IDLE && !rx_error_status.framing_err;
  endproperty
  a_one_stop: assert property (p_one_stop)
    else $error("good stop bit did not end frame cleanly");
  property p_msb_zero;
    rx_done && !async_mode_control.char_len8 && fq_in_ready
      && !fq_out_valid && !rxb_full_ff ##1 fq_out_valid |=> !rx_buffer[7];
  endproperty
  a_msb_zero: assert property (p_msb_zero)
    else $error("seven-bit data has top bit set");
  property p_rd_shared;
    rx_rd && rxb_full_ff && !fq_out_valid |=> !rx_full ##0 $stable(rx_buffer);
  endproperty
  a_rd_shared: assert property (p_rd_shared)
    else $error("read did not drain receive buffer");

  // ----------------------------------------
  // Pin routing
  // ----------------------------------------
  always_comb begin
    // unused pins follow the port latches
    pin_out = port_out;
    pin_oe = port_oe;
    if (rx_on) begin
      if (line_pin_select[0]) begin
        pin_oe.alternate_rx_pin = 1'b0;
      end else begin
        pin_oe.primary_rx_pin = 1'b0;
      end
    end
    if (tx_on) begin
      pin_out.primary_tx_pin = line_pin_select[1] ? 1'b1 : tx_line_ff;
      pin_oe.primary_tx_pin = 1'b1;
      if (line_pin_select[1]) begin
        pin_out.alternate_tx_pin = tx_line_ff;
        pin_oe.alternate_tx_pin = 1'b1;
      end
    end
    // external clock pin taken only when selected
    if ((tx_on || rx_on) && !async_mode_control.clk_internal) begin
      pin_oe.ext_baud_clock_pin = 1'b0;
    end
  end

  property p_pin_release;
    !tx_on && !rx_on |-> pin_out == port_out && pin_oe == port_oe;
  endproperty
  a_pin_release: assert property (p_pin_release)
    else $error("idle channel holds a port pin");
  property p_alt_tx_high;
    tx_on && line_pin_select == UMPR_SEL_TXALT |-> pin_out.primary_tx_pin
      && pin_oe.primary_tx_pin && pin_out.alternate_tx_pin == tx_line_ff;
  endproperty
  a_alt_tx_high: assert property (p_alt_tx_high)
    else $error("alternate tx routing wrong");
endmodule : umpr_uart
